/* File: include/core_decode_pkg.sv */
// Constants, encodings and types for the instruction decode and timing block
package core_decode_pkg;
	// =========================================================
	// Word layout
	localparam int WORD_W = 16;
	localparam int PC_W = 20;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	localparam logic [3:0] SECOND_WORD_PREFIX = 4'hf;
	localparam logic [PC_W-1:0] PC_RESET = 20'h00000;
	// =========================================================
	// Opcode prefixes
	localparam logic [6:0] SKIP_ZERO_PREFIX = 7'h33;
	localparam logic [7:0] GOTO_PREFIX = 8'hef;
	localparam logic [6:0] CALL_PREFIX = 7'h76;
	localparam logic [7:0] LFSR_PREFIX = 8'hee;
	localparam logic [3:0] MOVE_FF_PREFIX = 4'hc;
	localparam logic [4:0] BRANCH_PREFIX = 5'h1a;
	localparam logic [5:0] BYTE_LOW_PREFIX = 6'h01;
	// =========================================================
	// Field positions
	localparam int DEST_BIT = 9;
	localparam int ACCESS_BIT = 8;
	localparam int BIT_SEL_LSB = 9;
	localparam int BRANCH_OFF_W = 11;
	// =========================================================
	// Addressing
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	// =========================================================
	// Timing and types
	localparam int PHASES = 4;
	localparam int STANDARD_COUNT = 75;
	localparam int EXTENDED_COUNT = 8;
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b10,
		PH_Q4 = 2'b11
	} phase_t;
	typedef enum logic [1:0] {
		CLS_BYTE = 2'b00,
		CLS_BIT = 2'b01,
		CLS_LITERAL = 2'b10,
		CLS_CONTROL = 2'b11
	} cls_t;
endpackage

/* File: include/decode_if.sv */
// Signals shared by the core, its phase sequencer and its operand decoder
`timescale 1ns/10ps
interface decode_if;
	import core_decode_pkg::*;
	logic [15:0] ir;
	phase_t phase;
	logic cycle_end;
	cls_t cls;
	logic is_double_first;
	logic is_second_word;
	logic is_skip_test;
	logic is_goto;
	logic is_branch;
	logic dest_file;
	logic access_bank;
	logic [7:0] file_field;
	logic [2:0] bit_sel;
	logic [BRANCH_OFF_W-1:0] branch_off;
	modport seq (output phase, output cycle_end);
	modport dec (input ir, output cls, output is_double_first, output is_second_word,
		output is_skip_test, output is_goto, output is_branch, output dest_file,
		output access_bank, output file_field, output bit_sel, output branch_off);
	modport core (output ir, input phase, input cycle_end, input cls,
		input is_double_first, input is_second_word, input is_skip_test, input is_goto,
		input is_branch, input dest_file, input access_bank, input file_field,
		input bit_sel, input branch_off);
endinterface

/* File: rtl/phase_sequencer.sv */
// Four-phase sequencer dividing the oscillator into instruction cycles
`timescale 1ns/10ps
module phase_sequencer
	import core_decode_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	decode_if.seq bus
);
	phase_t phase;
	phase_t next_phase;

	// =========================================================
	// Phase rotation
	always_comb begin
		unique case (phase)
			PH_Q1: next_phase = PH_Q2;
			PH_Q2: next_phase = PH_Q3;
			PH_Q3: next_phase = PH_Q4;
			PH_Q4: next_phase = PH_Q1;
		endcase
	end

	// Every rising oscillator edge advances one phase
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= PH_Q1;
		end else begin
			phase <= next_phase;
		end
	end

	assign bus.phase = phase;
	assign bus.cycle_end = (phase == PH_Q4);

	a_cycle_four: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus.cycle_end |=> !bus.cycle_end [*3] ##1 bus.cycle_end)
		else $error("instruction cycle is not four phases long");
endmodule // phase_sequencer

/* File: rtl/operand_decoder.sv */
// Field extraction and classification of the instruction word in execution
`timescale 1ns/10ps
module operand_decoder
	import core_decode_pkg::*;
(
	decode_if.dec bus
);
	// Class of a word; shared by the decode of the current word
	function automatic cls_t word_class(input logic [15:0] w);
		if (w[15:12] >= 4'h1 && w[15:12] <= 4'h6) begin
			word_class = CLS_BYTE;
		end else if (w[15:10] == BYTE_LOW_PREFIX) begin
			word_class = CLS_BYTE;
		end else if (w[15:12] >= 4'h7 && w[15:12] <= 4'hb) begin
			word_class = CLS_BIT;
		end else if (w[15:12] == 4'h0) begin
			word_class = CLS_LITERAL;
		end else begin
			word_class = CLS_CONTROL;
		end
	endfunction

	// Exactly four encodings open a two-word instruction
	function automatic logic double_first(input logic [15:0] w);
		double_first = (w[15:12] == MOVE_FF_PREFIX) || (w[15:8] == GOTO_PREFIX)
			|| (w[15:9] == CALL_PREFIX) || (w[15:8] == LFSR_PREFIX);
	endfunction

	// =========================================================
	// Classification over the standard and extended opcode space
	assign bus.cls = word_class(bus.ir);
	assign bus.is_double_first = double_first(bus.ir);
	assign bus.is_second_word = (bus.ir[15:12] == SECOND_WORD_PREFIX);
	assign bus.is_skip_test = (bus.ir[15:9] == SKIP_ZERO_PREFIX);
	assign bus.is_goto = (bus.ir[15:8] == GOTO_PREFIX);
	assign bus.is_branch = (bus.ir[15:11] == BRANCH_PREFIX);

	// =========================================================
	// Operand fields below the opcode
	assign bus.dest_file = bus.ir[DEST_BIT];
	assign bus.access_bank = bus.ir[ACCESS_BIT];
	assign bus.file_field = bus.ir[7:0];
	assign bus.bit_sel = bus.ir[BIT_SEL_LSB+2:BIT_SEL_LSB];
	assign bus.branch_off = bus.ir[BRANCH_OFF_W-1:0];
endmodule // operand_decoder

/* File: rtl/instruction_core.sv */
// Fetch, decode and phase timing of the instruction stream
`timescale 1ns/10ps
module instruction_core
	import core_decode_pkg::*;
#(
	parameter int ADDR_W = PC_W
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [15:0] prog_rdata,
	output logic [ADDR_W-1:0] prog_addr,
	input wire logic [7:0] file_rdata,
	output logic [11:0] file_addr,
	output logic file_rd,
	input wire logic ext_enable,
	input wire logic [3:0] bank_select_register,
	output logic indexed_mode,
	output logic result_to_working,
	output logic result_to_file,
	output logic [7:0] bit_mask,
	output logic [15:0] exec_word,
	output logic exec_nop,
	output logic second_word_active,
	output logic skip_taken,
	output logic [3:0] q_phase
);
	decode_if bus ();

	phase_sequencer u_seq (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.bus(bus)
	);

	operand_decoder u_dec (
		.bus(bus)
	);

	assign bus.ir = exec_word;

	// =========================================================
	// Core state
	logic [ADDR_W-1:0] pc;
	logic prev_double;
	logic skip_zero;
	logic [ADDR_W-1:0] next_pc;
	logic [15:0] next_exec_word;
	logic next_prev_double;
	logic next_skip_zero;
	logic [11:0] next_file_addr;
	logic next_file_rd;
	logic next_indexed_mode;
	logic next_result_to_working;
	logic next_result_to_file;
	logic [7:0] next_bit_mask;
	logic next_exec_nop;
	logic next_second_word_active;
	logic next_skip_taken;
	logic [3:0] next_q_phase;

	// Word is live unless it is a stray second word or the second word of a two-word instruction
	logic stray;
	logic live;
	logic file_op;
	logic flush;
	logic [ADDR_W-1:0] branch_ext;

	assign stray = bus.is_second_word && !prev_double;
	assign live = !stray && !prev_double;
	assign file_op = live && (bus.cls == CLS_BYTE || bus.cls == CLS_BIT);
	assign branch_ext = ADDR_W'($signed(bus.branch_off));
	// A taken test or a relative branch drops the word fetched meanwhile
	assign flush = skip_zero || (live && bus.is_branch);

	// =========================================================
	// Next-state logic, stepped by phase
	always_comb begin
		next_pc = pc;
		next_exec_word = exec_word;
		next_prev_double = prev_double;
		next_skip_zero = skip_zero;
		next_file_addr = file_addr;
		next_file_rd = file_rd;
		next_indexed_mode = indexed_mode;
		next_result_to_working = result_to_working;
		next_result_to_file = result_to_file;
		next_bit_mask = bit_mask;
		next_exec_nop = exec_nop;
		next_second_word_active = second_word_active;
		next_skip_taken = skip_taken;
		next_q_phase = q_phase;
		unique case (bus.phase)
			PH_Q1: begin
				// Decode: resolve the file address for Q2
				next_q_phase = 4'h2;
				next_exec_nop = stray;
				next_second_word_active = prev_double;
				next_file_rd = file_op;
				next_indexed_mode = 1'b0;
				if (!bus.access_bank) begin
					if (ext_enable && bus.file_field <= INDEXED_LIMIT) begin
						next_indexed_mode = file_op;
						next_file_addr = {ACCESS_LOW_BANK, bus.file_field};
					end else if (bus.file_field <= INDEXED_LIMIT) begin
						next_file_addr = {ACCESS_LOW_BANK, bus.file_field};
					end else begin
						next_file_addr = {ACCESS_HIGH_BANK, bus.file_field};
					end
				end else begin
					next_file_addr = {bank_select_register, bus.file_field};
				end
			end
			PH_Q2: begin
				// Read register f; the zero test needs no status update
				next_q_phase = 4'h4;
				next_file_rd = 1'b0;
				next_skip_zero = live && bus.is_skip_test && (file_rdata == 8'h00);
			end
			PH_Q3: begin
				// Process: present destination and bit select for Q4
				next_q_phase = 4'h8;
				next_skip_taken = skip_zero;
				next_result_to_working = live && bus.cls == CLS_BYTE && !bus.is_skip_test
					&& !bus.dest_file;
				next_result_to_file = live && bus.cls == CLS_BYTE && !bus.is_skip_test
					&& bus.dest_file;
				next_bit_mask = (live && bus.cls == CLS_BIT) ? (8'h01 << bus.bit_sel) : 8'h00;
			end
			PH_Q4: begin
				// Cycle end: load the prefetched word and move the fetch
				next_q_phase = 4'h1;
				next_result_to_working = 1'b0;
				next_result_to_file = 1'b0;
				next_bit_mask = 8'h00;
				next_skip_taken = 1'b0;
				next_skip_zero = 1'b0;
				next_exec_word = flush ? NOP_WORD : prog_rdata;
				next_prev_double = !flush && live && bus.is_double_first;
				if (live && bus.is_goto) begin
					// Target high bits ride in the second word now on the bus
					next_pc = ADDR_W'({prog_rdata[11:0], bus.file_field});
				end else if (live && bus.is_branch) begin
					next_pc = pc + branch_ext;
				end else begin
					next_pc = pc + ADDR_W'(1);
				end
			end
		endcase
	end

	// Registers of the core; reset leaves a NOP in execution
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc <= ADDR_W'(PC_RESET);
			exec_word <= NOP_WORD;
			prev_double <= 1'b0;
			skip_zero <= 1'b0;
			file_addr <= 12'h000;
			file_rd <= 1'b0;
			indexed_mode <= 1'b0;
			result_to_working <= 1'b0;
			result_to_file <= 1'b0;
			bit_mask <= 8'h00;
			exec_nop <= 1'b0;
			second_word_active <= 1'b0;
			skip_taken <= 1'b0;
			q_phase <= 4'h1;
		end else begin
			pc <= next_pc;
			exec_word <= next_exec_word;
			prev_double <= next_prev_double;
			skip_zero <= next_skip_zero;
			file_addr <= next_file_addr;
			file_rd <= next_file_rd;
			indexed_mode <= next_indexed_mode;
			result_to_working <= next_result_to_working;
			result_to_file <= next_result_to_file;
			bit_mask <= next_bit_mask;
			exec_nop <= next_exec_nop;
			second_word_active <= next_second_word_active;
			skip_taken <= next_skip_taken;
			q_phase <= next_q_phase;
		end
	end

	// Fetch address is the program counter itself
	assign prog_addr = pc;

	// =========================================================
	// Checks
	a_phase_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
		q_phase == 4'h1 |=> q_phase == 4'h2 ##1 q_phase == 4'h4 ##1 q_phase == 4'h8)
		else $error("phase outputs out of order");

	a_stray_nop: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.phase == PH_Q1 && stray) |=> exec_nop && !file_rd)
		else $error("stray second word did not execute as nop");

	a_second_word: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.cycle_end && !flush && live && bus.is_double_first) |=> ##1 second_word_active)
		else $error("two-word instruction missing its second cycle");

	a_dest_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
		result_to_working |-> bus.cls == CLS_BYTE && !bus.dest_file && !result_to_file)
		else $error("working register result without destination zero");

	a_access_bsr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(file_rd && bus.access_bank) |-> file_addr == {$past(bank_select_register), bus.file_field})
		else $error("banked address does not use bank select");

	// Looked at in Q2 only: by the next Q1 edge the word in execution has moved on
	a_indexed_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bus.phase == PH_Q2 |-> indexed_mode == (file_rd && !bus.access_bank
		&& $past(ext_enable) && bus.file_field <= INDEXED_LIMIT))
		else $error("indexed mode without its conditions");

	a_bit_mask: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bit_mask != 8'h00 |-> bit_mask == (8'h01 << bus.bit_sel) && bus.cls == CLS_BIT)
		else $error("bit mask does not match bit select");

	a_skip_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		$rose(skip_taken) |-> $past(file_rdata, 2) == 8'h00 && bus.is_skip_test)
		else $error("skip taken on nonzero register");

	a_skip_flush: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skip_taken |=> exec_word == NOP_WORD && !second_word_active [*4])
		else $error("skipped word was not replaced by nop");

	a_branch_flush: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.cycle_end && live && bus.is_branch) |=> exec_word == NOP_WORD && $changed(pc))
		else $error("branch did not flush the prefetched word");

	a_fetch_overlap: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.cycle_end && !flush) |=> exec_word == $past(prog_rdata))
		else $error("prefetched word not taken into execution");

	// =========================================================
	// Pulse widths, jump targets and bank split
	// A strobe that lingers into the next word would act on the wrong register
	a_read_strobe: assert property (@(posedge ref_clk) disable iff (sys_rst)
		file_rd |-> bus.phase == PH_Q2 && file_op)
		else $error("file read strobe outside Q2");

	a_skip_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.phase == PH_Q4 && live && bus.is_skip_test) |-> !result_to_working
		&& !result_to_file && bit_mask == 8'h00)
		else $error("zero test produced a result");

	a_skip_three: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skip_taken |=> ##5 (exec_nop == bus.is_second_word && !second_word_active))
		else $error("word after a skipped word not handled as nop");

	a_goto_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.cycle_end && live && bus.is_goto)
		|=> pc == ADDR_W'({$past(prog_rdata[11:0]), $past(bus.file_field)}))
		else $error("jump target not built from both words");

	a_branch_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus.cycle_end && live && bus.is_branch) |=> pc == $past(pc) + $past(branch_ext))
		else $error("relative branch landed on the wrong address");

	a_result_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(result_to_working || result_to_file) |-> bus.phase == PH_Q4
		##1 (!result_to_working && !result_to_file))
		else $error("result strobe not a single Q4 pulse");

	a_file_dest: assert property (@(posedge ref_clk) disable iff (sys_rst)
		result_to_file |-> bus.cls == CLS_BYTE && bus.dest_file && !result_to_working)
		else $error("file register result without destination one");

	a_mask_onehot: assert property (@(posedge ref_clk) disable iff (sys_rst)
		bit_mask != 8'h00 |-> $onehot(bit_mask) && bus.phase == PH_Q4)
		else $error("bit mask not one hot in Q4");

	a_skip_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		skip_taken |-> bus.phase == PH_Q4 && skip_zero)
		else $error("skip flag outside Q4 or without a zero test");

	a_nop_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
		exec_word == NOP_WORD |-> !file_rd && !result_to_working && !result_to_file
		&& bit_mask == 8'h00 && !skip_taken)
		else $error("nop word produced activity");

	a_second_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
		second_word_active |-> !file_rd && !exec_nop && !result_to_working && !result_to_file)
		else $error("second word cycle produced activity");

	// Fetch address must hold for the whole cycle so the store can answer in time
	a_pc_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!bus.cycle_end |=> $stable(pc))
		else $error("fetch address moved inside a cycle");

	a_access_split: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(file_rd && !bus.access_bank) |-> file_addr[11:8]
		== ((bus.file_field <= INDEXED_LIMIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
		else $error("access bank split wrong");
endmodule // instruction_core

/* File: bench/prog_mem.sv */
// Program memory model answering the core's prefetch address
`timescale 1ns/10ps
module prog_mem
	import core_decode_pkg::*;
(
	input wire logic [PC_W-1:0] prog_addr,
	output logic [15:0] prog_rdata
);
	logic [15:0] mem [0:63];

	// =========================================================
	// Store lookup
	// Answers at once, well before the Q4 sampling edge
	always_comb begin
		if (prog_addr < 20'h00040) begin
			prog_rdata = mem[prog_addr[5:0]];
		end else begin
			prog_rdata = NOP_WORD; // Unloaded space reads as NOP
		end
	end
endmodule // prog_mem

/* File: bench/testbench.sv */
// Self-checking bench for the instruction decode and timing core
`timescale 1ns/10ps
module testbench;
	import core_decode_pkg::*;
	typedef struct {
		logic [15:0] w;
		logic rw, rf, sk, nop, sec, rd, idx;
		logic [7:0] m;
		logic [11:0] fa;
	} exp_t;
	logic ref_clk, sys_rst, file_rd, ext_enable, indexed_mode, result_to_working;
	logic result_to_file, exec_nop, second_word_active, skip_taken, rd_seen;
	logic [15:0] prog_rdata, exec_word;
	logic [PC_W-1:0] prog_addr;
	logic [7:0] file_rdata, bit_mask, f0, f1, f2, f3, f4;
	logic [11:0] file_addr, r8, r9;
	logic [3:0] bank_select_register, q_phase, prev_ph;
	logic [2:0] b0, b1;
	logic [7:0] fmem [0:255];
	exp_t exp_q[$];
	exp_t e;
	int n_fail, samples_checked, i, run, x;

	// =========================================================
	// Clock, design and program store
	always #5 ref_clk = ~ref_clk;
	instruction_core instruction_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.prog_rdata(prog_rdata), .prog_addr(prog_addr), .file_rdata(file_rdata),
		.file_addr(file_addr), .file_rd(file_rd), .ext_enable(ext_enable),
		.bank_select_register(bank_select_register), .indexed_mode(indexed_mode),
		.result_to_working(result_to_working), .result_to_file(result_to_file),
		.bit_mask(bit_mask), .exec_word(exec_word), .exec_nop(exec_nop),
		.second_word_active(second_word_active), .skip_taken(skip_taken), .q_phase(q_phase));
	prog_mem prog_mem_inst (.prog_addr(prog_addr), .prog_rdata(prog_rdata));

	// =========================================================
	// Data memory: valid only while strobed, so a late sample sees junk
	always @(posedge ref_clk) begin
		#1;
		file_rdata <= (file_rd === 1'b1) ? fmem[file_addr[7:0]] : ~file_rdata;
	end

	// =========================================================
	// Shared compare
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, want);
		end
	endtask

	task automatic note(input logic [15:0] w, input logic [1:0] res, input logic [7:0] m,
		input logic [2:0] flg, input logic rd, input logic idx, input logic [11:0] fa);
		exp_t n;
		n.w = w;
		{n.rw, n.rf} = res;
		n.m = m;
		{n.sk, n.nop, n.sec} = flg;
		n.rd = rd;
		n.idx = idx;
		n.fa = fa;
		exp_q.push_back(n);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// =========================================================
	// Monitor: phase rotation every clock, results once per cycle in Q4
	always @(posedge ref_clk) begin
		#2;
		if (sys_rst) begin
			prev_ph = 4'h8; // Release edge then shows Q1 as the rotation of Q4
			check(q_phase, 4'h1, "reset phase");
			check(exec_word, NOP_WORD, "reset word");
		end else begin
			check(q_phase, {prev_ph[2:0], prev_ph[3]}, "phase");
			prev_ph = q_phase;
			if (q_phase === 4'h2) begin
				rd_seen = file_rd;
			end
			if (q_phase === 4'h8 && exp_q.size() > 0) begin
				e = exp_q.pop_front();
				check(exec_word, e.w, "word");
				check(result_to_working, e.rw, "to working");
				check(result_to_file, e.rf, "to file");
				check(bit_mask, e.m, "mask");
				check(skip_taken, e.sk, "skip");
				check(exec_nop, e.nop, "stray");
				check(second_word_active, e.sec, "second");
				check(rd_seen, e.rd, "read");
				if (e.w === 16'hf000) begin
					check(prog_addr[15:0], 16'h0020, "goto lands");
				end
				if (e.w === {8'h6a, f1}) begin
					check(prog_addr[15:0], 16'h0027, "branch lands");
				end
				if (e.rd) begin
					check(file_addr, e.fa, "addr");
					check(indexed_mode, e.idx, "indexed");
				end
			end
		end
	end

	// =========================================================
	// Watchdog sized for two short programs
	initial begin
		#(400 * 10);
		n_fail++;
		wrap_up();
	end

	// =========================================================
	// Main: same program with the extended set on, then off after a reset
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		ext_enable = 1'b1;
		bank_select_register = 4'h0;
		file_rdata = 8'h00;
		n_fail = 0;
		samples_checked = 0;
		x = $urandom(32'h8c9b9032);
		for (run = 0; run < 2; run++) begin
			@(posedge ref_clk);
			#1;
			sys_rst = 1'b1;
			ext_enable = (run == 0);
			exp_q.delete();
			for (i = 0; i < 256; i++) fmem[i] = 8'(($urandom % 255) + 1);
			fmem[8'h10] = 8'h00; // The one zero location
			for (i = 0; i < 64; i++) prog_mem_inst.mem[i] = NOP_WORD;
			f0 = 8'($urandom % 96);
			f1 = 8'(8'h60 + ($urandom % 160));
			f2 = 8'($urandom);
			f3 = 8'(8'h20 + ($urandom % 32));
			f4 = 8'($urandom);
			b0 = 3'($urandom);
			b1 = 3'($urandom);
			r8 = 12'($urandom);
			r9 = 12'($urandom);
			bank_select_register = 4'($urandom);
			prog_mem_inst.mem[0] = {8'h24, f0};
			prog_mem_inst.mem[1] = {8'h26, f1};
			prog_mem_inst.mem[2] = {4'h8, b0, 1'b1, f2};
			prog_mem_inst.mem[3] = {8'h66, f3};
			prog_mem_inst.mem[4] = 16'h6610;
			prog_mem_inst.mem[5] = {8'h26, f1};
			prog_mem_inst.mem[6] = 16'h6610;
			prog_mem_inst.mem[7] = 16'hef30; // Skipped jump must not land
			prog_mem_inst.mem[8] = {4'hf, r8};
			prog_mem_inst.mem[9] = {4'hf, r9};
			prog_mem_inst.mem[10] = 16'hef20;
			prog_mem_inst.mem[11] = 16'hf000;
			prog_mem_inst.mem[32] = {4'h8, b1, 1'b1, f4};
			prog_mem_inst.mem[33] = 16'hd004; // Relative branch four past the fetch address
			prog_mem_inst.mem[34] = {8'h24, f0}; // Flushed by the branch
			prog_mem_inst.mem[38] = {8'h6a, f1};
			note(NOP_WORD, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note({8'h24, f0}, 2'b10, 8'h00, 3'b000, 1'b1, ext_enable, {4'h0, f0});
			note({8'h26, f1}, 2'b01, 8'h00, 3'b000, 1'b1, 1'b0, {4'hf, f1});
			note({4'h8, b0, 1'b1, f2}, 2'b00, 8'h01 << b0, 3'b000, 1'b1, 1'b0,
				{bank_select_register, f2});
			note({8'h66, f3}, 2'b00, 8'h00, 3'b000, 1'b1, ext_enable, {4'h0, f3});
			note(16'h6610, 2'b00, 8'h00, 3'b100, 1'b1, ext_enable, 12'h010);
			note(NOP_WORD, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note(16'h6610, 2'b00, 8'h00, 3'b100, 1'b1, ext_enable, 12'h010);
			note(NOP_WORD, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note({4'hf, r8}, 2'b00, 8'h00, 3'b010, 1'b0, 1'b0, 12'h000);
			note({4'hf, r9}, 2'b00, 8'h00, 3'b010, 1'b0, 1'b0, 12'h000);
			note(16'hef20, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note(16'hf000, 2'b00, 8'h00, 3'b001, 1'b0, 1'b0, 12'h000);
			note({4'h8, b1, 1'b1, f4}, 2'b00, 8'h01 << b1, 3'b000, 1'b1, 1'b0,
				{bank_select_register, f4});
			note(16'hd004, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note(NOP_WORD, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			note({8'h6a, f1}, 2'b01, 8'h00, 3'b000, 1'b1, 1'b0, {4'hf, f1});
			note(NOP_WORD, 2'b00, 8'h00, 3'b000, 1'b0, 1'b0, 12'h000);
			repeat (2) @(posedge ref_clk);
			#1;
			sys_rst = 1'b0;
			for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge ref_clk);
			if (exp_q.size() > 0) begin
				n_fail++; // Expected results never appeared
			end
			$display("test %0d ended, extended set %0d", run, ext_enable);
		end
		wrap_up();
	end
endmodule // testbench
